// ==== logic/bmsi_ctrl.sv ====
// Purpose: Drives a multiplexed byte bus to a paged 128Kx8 static RAM.
// Assumes: Requests and settings are synchronous to clk.
// Notes:   All pin outputs are registered; settings apply while idle.
`default_nettype none

module bmsi_ctrl (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Settings.
  input  wire logic                         ext_port_route,
  input  wire logic                         bus_enable,
  input  wire logic                         page_cfg,
  input  wire logic [bmsi_pkg::WAIT_W-1:0]  wait_cfg,
  input  wire logic                         wait_load,
  output logic                              configured,
  // Access requests.
  input  wire logic                         req_valid,
  input  wire logic                         req_write,
  input  wire logic [bmsi_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [bmsi_pkg::DATA_W-1:0]  req_wdata,
  output logic                              req_ready,
  output logic                              req_error,
  output logic                              rsp_valid,
  output logic [bmsi_pkg::DATA_W-1:0]       rsp_rdata,
  // Memory pins.
  output logic                              mem_bus_enable_n,
  output logic                              page_select,
  output logic                              ale,
  output logic                              rd_n,
  output logic                              wr_n,
  output logic [bmsi_pkg::ADDR_W-1:8]       addr_hi,
  output logic [bmsi_pkg::DATA_W-1:0]       ad_out,
  output logic                              ad_oe,
  input  wire logic [bmsi_pkg::DATA_W-1:0]  ad_in
);

  bmsi_pkg::bmsi_state_t                 state;
  bmsi_pkg::bmsi_state_t                 next_state;
  logic [bmsi_pkg::ADDR_W-1:0]           addr_q;
  logic [bmsi_pkg::DATA_W-1:0]           wdata_q;
  logic                                  write_q;
  logic [bmsi_pkg::WAIT_W-1:0]           wait_reg;
  logic [bmsi_pkg::WAIT_W-1:0]           ws_q;

  bmsi_phase_if ph ();

  bmsi_phase_timer u_timer (
    .clk (clk),
    .rst (rst),
    .ph  (ph.tmr)
  );

  // Request decode: an access starts only once fully set up.
  logic take;
  logic access_ok;
  logic go;
  logic refuse;
  logic cfg_upd;
  assign take      = req_valid && req_ready;
  assign access_ok = ext_port_route && !mem_bus_enable_n && configured;
  assign go        = take && access_ok;
  assign refuse    = take && !access_ok;
  assign cfg_upd   = (state == bmsi_pkg::ST_IDLE) && !go;

  // Next access fields, taken straight from the request on acceptance.
  logic [bmsi_pkg::ADDR_W-1:0] next_addr;
  logic [bmsi_pkg::DATA_W-1:0] next_wdata;
  logic                        next_write;
  assign next_addr  = go ? req_addr : addr_q;
  assign next_wdata = go ? req_wdata : wdata_q;
  assign next_write = go ? req_write : write_q;

  // Sequencer: address, hold, strobe, recovery, each timed by the timer.
  always_comb begin
    next_state = state;
    case (state)
      bmsi_pkg::ST_IDLE: begin
        if (go) begin
          next_state = bmsi_pkg::ST_ADDR;
        end
      end
      bmsi_pkg::ST_ADDR: begin
        if (ph.done) begin
          next_state = bmsi_pkg::ST_HOLD;
        end
      end
      bmsi_pkg::ST_HOLD: begin
        if (ph.done) begin
          next_state = bmsi_pkg::ST_STRB;
        end
      end
      bmsi_pkg::ST_STRB: begin
        if (ph.done) begin
          next_state = bmsi_pkg::ST_RCOV;
        end
      end
      bmsi_pkg::ST_RCOV: begin
        if (ph.done) begin
          next_state = bmsi_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = bmsi_pkg::ST_IDLE;
      end
    endcase
  end

  // Phase lengths; the strobe stretches by the latched wait states.
  logic in_addr;
  logic in_hold;
  logic in_strb;
  logic in_rcov;
  assign in_addr  = next_state == bmsi_pkg::ST_ADDR;
  assign in_hold  = next_state == bmsi_pkg::ST_HOLD;
  assign in_strb  = next_state == bmsi_pkg::ST_STRB;
  assign in_rcov  = next_state == bmsi_pkg::ST_RCOV;
  assign ph.load  = (state != next_state) &&
                    (next_state != bmsi_pkg::ST_IDLE);
  assign ph.len   = in_addr ? bmsi_pkg::ALE_CYC - bmsi_pkg::ONE_CYC :
                    in_hold ? bmsi_pkg::HOLD_CYC - bmsi_pkg::ONE_CYC :
                    in_strb ? ws_q :
                    bmsi_pkg::RECOV_CYC - bmsi_pkg::ONE_CYC;

  // Pin values for the next cycle.
  logic next_ale;
  logic next_rd_n;
  logic next_wr_n;
  logic next_ad_oe;
  logic [bmsi_pkg::DATA_W-1:0] next_ad_out;
  logic last_read;
  assign next_ale    = in_addr;
  assign next_rd_n   = !(in_strb && !next_write);
  assign next_wr_n   = !(in_strb && next_write);
  assign next_ad_oe  = in_addr || in_hold ||
                       ((in_strb || in_rcov) && next_write);
  assign next_ad_out = (in_addr || in_hold) ?
                       next_addr[bmsi_pkg::HI_LSB-1:0] : next_wdata;
  assign last_read   = (state == bmsi_pkg::ST_STRB) && ph.done && !write_q;

  // State and captured request; the wait count is frozen per access.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= bmsi_pkg::ST_IDLE;
      addr_q  <= '0;
      wdata_q <= '0;
      write_q <= 1'b0;
      ws_q    <= bmsi_pkg::WAIT_RST;
    end else begin
      state   <= next_state;
      addr_q  <= next_addr;
      wdata_q <= next_wdata;
      write_q <= next_write;
      if (go) begin
        ws_q <= wait_reg;
      end
    end
  end

  // Wait-state setting; accesses are refused until it has been loaded.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_reg   <= bmsi_pkg::WAIT_RST;
      configured <= 1'b0;
    end else if (wait_load) begin
      wait_reg   <= wait_cfg;
      configured <= 1'b1;
    end
  end

  // Bus enable and page only change between accesses, so the RAM never
  // sees its chip enable or top address bit move under a strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_bus_enable_n <= 1'b1;
      page_select      <= 1'b0;
    end else if (cfg_upd) begin
      mem_bus_enable_n <= !bus_enable;
      page_select      <= page_cfg;
    end
  end

  // Pin drivers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ale     <= 1'b0;
      rd_n    <= 1'b1;
      wr_n    <= 1'b1;
      ad_oe   <= 1'b0;
      ad_out  <= '0;
      addr_hi <= '0;
    end else begin
      ale     <= next_ale;
      rd_n    <= next_rd_n;
      wr_n    <= next_wr_n;
      ad_oe   <= next_ad_oe;
      ad_out  <= next_ad_out;
      addr_hi <= next_addr[bmsi_pkg::ADDR_W-1:bmsi_pkg::HI_LSB];
    end
  end

  // Handshake and read data; data is caught in the last strobe cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
      req_error <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      req_ready <= next_state == bmsi_pkg::ST_IDLE;
      req_error <= refuse;
      rsp_valid <= last_read;
      if (last_read) begin
        rsp_rdata <= ad_in;
      end
    end
  end

  // Helper for the checks below: cycles the current strobe has lasted.
  logic       strobe;
  logic [4:0] low_cnt;
  assign strobe = !rd_n || !wr_n;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= '0;
    end else begin
      low_cnt <= strobe ? low_cnt + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  excl_strobes_a: assert property (rd_n || wr_n)
    else $error("Read and write strobes low together.");

  ale_first_a: assert property (
    $fell(rd_n && wr_n) |-> !ale && !$past(ale) && $past(ale, 2))
    else $error("Strobe without a latched address phase first.");

  bus_off_quiet_a: assert property (
    mem_bus_enable_n |-> rd_n && wr_n && !ale && !ad_oe)
    else $error("Bus activity while the bus enable is off.");

  read_release_a: assert property (!rd_n |-> !ad_oe)
    else $error("Low byte driven during a read strobe.");

  write_data_a: assert property (
    !wr_n |-> ad_oe && ad_out == wdata_q &&
              ($stable(ad_out) || $fell(wr_n)))
    else $error("Write strobe without stable write data.");

  addr_phase_a: assert property (
    $rose(ale) |-> ad_oe && ad_out == addr_q[7:0]
                   ##1 ale && $stable(ad_out) ##1 !ale && $stable(ad_out))
    else $error("Address byte not held around the latch strobe.");

  hi_addr_a: assert property (
    strobe |-> addr_hi == addr_q[15:8] && $stable(addr_hi))
    else $error("Upper address moved during a strobe.");

  strobe_len_a: assert property (
    $fell(strobe) |-> low_cnt == {1'b0, ws_q} + 5'h01)
    else $error("Strobe width does not match the wait states.");

  refuse_setup_a: assert property (
    take && !access_ok |=> req_error && !ale ##1 !ale && rd_n && wr_n)
    else $error("Access started without complete setup.");

  read_capture_a: assert property (
    rsp_valid |-> !$past(rd_n) && rd_n && rsp_rdata == $past(ad_in))
    else $error("Read data not taken at the end of the strobe.");

  page_hold_a: assert property (
    strobe |-> $stable(page_select) && !mem_bus_enable_n)
    else $error("Page or enable changed during a strobe.");

  full_speed_a: assert property (
    $rose(ale) |-> ##[4:22] $fell(strobe))
    else $error("Access did not reach its strobe in time.");

endmodule

`default_nettype wire

// ==== logic/bmsi_phase_if.sv ====
// Purpose: Carries phase-timer control between sequencer and timer.
// Assumes: Load and length are valid in the same cycle.
// Notes:   Done is high in the last cycle of a loaded phase.
`default_nettype none

interface bmsi_phase_if;
  logic                          load;
  logic [bmsi_pkg::TMR_W-1:0]    len;
  logic                          done;

  modport ctl (output load, output len, input done);
  modport tmr (input load, input len, output done);
endinterface

`default_nettype wire

// ==== logic/bmsi_phase_timer.sv ====
// Purpose: Counts the length of one access phase.
// Assumes: A load of len gives a phase of len plus one cycles.
// Notes:   Done is decoded from flops, so it is glitch free inside.
`default_nettype none

module bmsi_phase_timer (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Timer control.
  bmsi_phase_if.tmr ph
);

  logic [bmsi_pkg::TMR_W-1:0] cnt;
  logic                       running;

  // Done fires once the count reaches zero in an armed phase.
  assign ph.done = running && (cnt == '0);

  // Reload wins over expiry so phases may follow back to back.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt     <= '0;
      running <= 1'b0;
    end else if (ph.load) begin
      cnt     <= ph.len;
      running <= 1'b1;
    end else if (ph.done) begin
      running <= 1'b0;
    end else if (running) begin
      cnt     <= cnt - 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== logic/bmsi_pkg.sv ====
// Purpose: Shared constants and types of the banked multiplexed RAM port.
// Assumes: One 250 MHz clock; all counts are in clock cycles.
// Notes:   Phase lengths are counts of whole cycles, never zero.
`default_nettype none

package bmsi_pkg;

  // Bus geometry: 16-bit bus address, byte data, split at bit 8.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int HI_LSB = 8;

  // Phase timer width and the fixed phase lengths in cycles.
  localparam int         TMR_W        = 4;
  localparam logic [3:0] ALE_CYC      = 4'h2;
  localparam logic [3:0] HOLD_CYC     = 4'h1;
  localparam logic [3:0] RECOV_CYC    = 4'h1;
  localparam logic [3:0] ONE_CYC      = 4'h1;

  // Wait-state field; reset value is the slowest setting.
  localparam int         WAIT_W       = 4;
  localparam logic [3:0] WAIT_RST     = 4'hF;

  // Access sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_HOLD = 5'h04,
    ST_STRB = 5'h08,
    ST_RCOV = 5'h10
  } bmsi_state_t;

endpackage

`default_nettype wire

// ==== sim/banked_multiplexed_sram_interface_bench.sv ====
// Purpose: Self-checking bench of the paged multiplexed RAM controller.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   A reference memory keyed by page and address checks read data.
`default_nettype none

module banked_multiplexed_sram_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0, rst = 1'b1, ext_port_route = 1'b0, bus_enable = 1'b0;
  logic page_cfg = 1'b0, wait_load = 1'b0, req_valid = 1'b0;
  logic req_write = 1'b0, configured, req_ready, req_error, rsp_valid;
  logic [3:0] wait_cfg = 4'h0;
  logic [15:0] req_addr = 16'h0000;
  logic [7:0] req_wdata = 8'h00, rsp_rdata, ad_out, ad_in;
  logic mem_bus_enable_n, page_select, ale, rd_n, wr_n, ad_oe;
  logic [15:8] addr_hi;
  int num_errors = 0, checked = 0, wcur = 0;
  logic [31:0] seed = 32'h29B6;
  logic [7:0] ref_mem [int];
  int wq[$];

  always #2 clk = ~clk;

  bmsi_ctrl DUT (.clk, .rst, .ext_port_route, .bus_enable, .page_cfg,
    .wait_cfg, .wait_load, .configured, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .req_error, .rsp_valid, .rsp_rdata,
    .mem_bus_enable_n, .page_select, .ale, .rd_n, .wr_n, .addr_hi,
    .ad_out, .ad_oe, .ad_in);

  bmsi_sram_model #(.ACC_NS(2)) ram (.mem_bus_enable_n, .page_select,
    .ale, .rd_n, .wr_n, .addr_hi, .ad_out, .ad_oe, .ad_in);

  // Xorshift keeps the stimulus repeatable from run to run.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_cyc(input int got, input int exp);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("ERROR t=%0t cycles got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Counts: checked=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Page and bus enable are only copied while idle, so this is called between accesses.
  task automatic cfg(input logic [3:0] w, input logic pg);
    wait_cfg = w;
    wait_load = 1'b1;
    page_cfg = pg;
    tick();
    wait_load = 1'b0;
    tick();
    wcur = w;
    chk(16'(configured), 16'h0001);
    chk(16'(page_select), 16'(pg));
  endtask

  // One access; the expected timing follows the strobe of wcur plus one.
  task automatic access(input logic w, input logic [15:0] a,
                        input logic [7:0] d, input logic bad);
    int n;
    int key;
    key = int'({page_select, a});
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    // A controller that never gets ready again is a failure too.
    if (req_ready !== 1'b1) begin
      num_errors++;
    end
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    tick();
    req_valid = 1'b0;
    if (bad) begin
      chk(16'(req_error), 16'h0001);
      chk(16'(ale), 16'h0000);
      return;
    end
    chk(16'(ale), 16'h0001);
    chk(16'(ad_out), 16'(a[7:0]));
    chk(16'(addr_hi), 16'(a[15:8]));
    n = 1;
    if (w) begin
      ref_mem[key] = d;
      wq.push_back(key);
      while (req_ready !== 1'b1 && n < 60) begin
        tick();
        n++;
      end
      chk_cyc(n, wcur + 6);
    end else begin
      while (rsp_valid !== 1'b1 && n < 60) begin
        tick();
        n++;
      end
      chk_cyc(n, wcur + 5);
      chk(16'(rsp_rdata), 16'(ref_mem[key]));
    end
  endtask

  // Pin watcher: strobe exclusivity on every cycle with a strobe low, bus release on cycles with the read strobe low.
  always @(posedge clk) begin
    #1;
    if (!rst && (!rd_n || !wr_n)) begin
      chk(16'(rd_n | wr_n), 16'h0001);
      chk(16'(ale), 16'h0000);
      chk(16'(mem_bus_enable_n), 16'h0000);
      if (!rd_n) chk(16'(ad_oe), 16'h0000);
    end
  end

  initial begin
    int key;
    logic [31:0] r;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(16'(mem_bus_enable_n), 16'h0001);
    chk(16'({rd_n, wr_n}), 16'h0003);
    chk(16'(ad_oe), 16'h0000);
    bus_enable = 1'b1;
    ext_port_route = 1'b1;
    tick();
    tick();
    chk(16'(mem_bus_enable_n), 16'h0000);
    access(1'b0, 16'h1234, 8'h00, 1'b1);
    cfg(4'h0, 1'b0);
    ext_port_route = 1'b0;
    access(1'b1, 16'h0055, 8'hAA, 1'b1);
    ext_port_route = 1'b1;
    bus_enable = 1'b0;
    tick();
    tick();
    chk(16'(mem_bus_enable_n), 16'h0001);
    access(1'b1, 16'h0055, 8'hAA, 1'b1);
    bus_enable = 1'b1;
    tick();
    tick();
    // Same top address on both pages first, then random spots.
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      cfg((i == 2) ? 4'hF : {2'b00, r[21:20]}, (i < 2) ? i[0] : r[16]);
      access(1'b1, (i < 2) ? 16'hFFFF : r[15:0], r[31:24], 1'b0);
    end
    // Read back newest first, so rewritten places show the last value.
    while (wq.size() > 0) begin
      key = wq.pop_back();
      r = rnd();
      // The last read runs with the longest strobe as well.
      cfg((wq.size() == 0) ? 4'hF : {2'b00, r[1:0]}, key[16]);
      access(1'b0, key[15:0], 8'h00, 1'b0);
    end
    end_sim();
  end

  // A hang ends the run as a failure well past the expected length.
  initial begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule

`default_nettype wire

// ==== sim/bmsi_sram_model.sv ====
// Purpose: Behavioural 128Kx8 static RAM with its low address latch.
// Assumes: Pins come straight from the controller; no clock on this side.
// Notes:   A bus driven by neither side shows the inverse of the ad_out byte.
`default_nettype none

module bmsi_sram_model #(
  parameter int ACC_NS = 2
) (
  // Control pins.
  input  wire logic        mem_bus_enable_n,
  input  wire logic        page_select,
  input  wire logic        ale,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  // Address and shared byte lines.
  input  wire logic [15:8] addr_hi,
  input  wire logic [7:0]  ad_out,
  input  wire logic        ad_oe,
  output logic      [7:0]  ad_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [0:131071];
  logic [7:0] lat;
  logic [7:0] bus;
  logic [16:0] ram_addr;
  logic        ram_drv;

  // The page bit is the top RAM address line, the rest is latch and high.
  assign ram_addr = {page_select, addr_hi, lat};
  // The RAM only talks while selected and read-enabled.
  assign ram_drv = !mem_bus_enable_n && !rd_n;
  // Floating lines never echo the old byte, so stale reads cannot pass.
  assign bus = ad_oe ? ad_out : (ram_drv ? mem[ram_addr] : ~ad_out);
  // The access time is modelled on the whole bus path.
  assign #(ACC_NS) ad_in = bus;

  // The latch is transparent while the strobe is high.
  always_latch begin
    if (ale) begin
      lat = bus;
    end
  end

  // Data is stored at the end of the write pulse.
  always @(posedge wr_n) begin
    if (!mem_bus_enable_n) begin
      mem[ram_addr] = bus;
    end
  end
endmodule

`default_nettype wire
